// File: core/plic_pkg.sv
// Purpose: Constants and types for the indicator select and interrupt control block
// Assumes: Registers reached by a simple 5-bit register port from the management engine
// Notes: Functional notes follow
//
// Functional notes
// - Indicator one selector, eight codes, default speed
// - Indicator zero same codes, 111 link, default activity
// - Sixteen-bit read-write receive error counter
// - Read clears flags when read-clear enabled
// - Re-setup off: write one clears, unless a new onset falls in the same cycle
// - Re-setup on: write one keeps active flag
// - Wake, power-down, autoneg enables reset zero
// - All interrupt config bits reset zero, RW
// - Eight further per-event interrupt enables
// - Eleven sticky event flags, cleared by write one or read
`default_nettype none
package plic_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] REG_IND_CTRL = 5'h14;
    localparam logic [4:0] REG_RXERR_CNT = 5'h15;
    localparam logic [4:0] REG_INT_CTRL = 5'h16;
    localparam logic [4:0] REG_INT_FLAGS = 5'h17;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int IND1_LSB = 3;
    localparam int IND0_LSB = 0;
    localparam logic [15:0] IND_CTRL_RST = 16'h3fe9;
    localparam logic [15:0] INT_CTRL_RST = 16'h0000;
    localparam logic [15:0] RXERR_CNT_RST = 16'h0000; // Counter value after reset
    localparam logic [15:0] RXERR_CNT_MAX = 16'hffff; // Counter holds here, no wrap
    localparam int INT_OE_BIT = 15;
    localparam int INT_RDCLR_BIT = 14;
    localparam int INT_POL_BIT = 13;
    localparam int INT_AUTOCLR_BIT = 12;
    localparam int INT_RESETUP_BIT = 11;
    localparam int NUM_EVENTS = 11;
    // Indicator source codes
    typedef enum logic [2:0] {
        IND_LINK = 3'h0, IND_ACT = 3'h1, IND_TX = 3'h2, IND_RX = 3'h3,
        IND_COL = 3'h4, IND_SPEED = 3'h5, IND_FDX = 3'h6, IND_SPECIAL = 3'h7
    } plic_ind_sel_t;
    // Link state bundle feeding the indicators
    typedef struct packed {
        logic link;
        logic activity;
        logic transmit;
        logic receive;
        logic collision;
        logic speed100;
        logic fullDuplex;
    } plic_link_t;
    // Register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } plic_req_t;
endpackage
`default_nettype wire

// File: core/plic_ctrl.sv
// Purpose: Indicator source select, receive error counter, interrupt flag control
// Assumes: Inputs synchronous to ref_clk; req.rd/req.wr are one-cycle strobes
// Notes: Event vector bit n matches flag register bit n (10 wake .. 0 link up)
`default_nettype none
module plic_ctrl
    import plic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire plic_req_t req,
    output logic [15:0] rdata,
    input wire plic_link_t linkSt,
    input wire logic rxErrPulse,
    input wire logic [NUM_EVENTS-1:0] evtCond,
    output logic indicatorOne,
    output logic indicatorZero,
    output logic intOut,
    output logic intOe_n
);
    // ****************************************
    // Helpers
    // ****************************************
    // Map a selector code to its source level
    function automatic logic pickSrc(input logic [2:0] sel, input plic_link_t l,
                                     input logic specialVal);
        case (plic_ind_sel_t'(sel))
            IND_LINK: pickSrc = l.link;
            IND_ACT: pickSrc = l.activity;
            IND_TX: pickSrc = l.transmit;
            IND_RX: pickSrc = l.receive;
            IND_COL: pickSrc = l.collision;
            IND_SPEED: pickSrc = l.speed100;
            IND_FDX: pickSrc = l.fullDuplex;
            default: pickSrc = specialVal;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [15:0] indCtrl_q, indCtrl_d; // Indicator select register
    logic [15:0] rxErr_q, rxErr_d; // Receive error counter
    logic [15:0] intCtrl_q, intCtrl_d; // Interrupt config and enables
    logic [NUM_EVENTS-1:0] flags_q, flags_d; // Sticky event flags
    logic [NUM_EVENTS-1:0] evtPrev_q; // Condition of last cycle, for edges
    logic [15:0] rdata_d; // Read data next value
    logic ind1_q, ind0_q, int_q, oe_q; // Registered outputs
    logic ind1_d, ind0_d, int_d, oe_d; // Output next values
    logic [NUM_EVENTS-1:0] evtRise; // Condition onset
    logic anyPending; // Enabled flag set

    assign evtRise = evtCond & ~evtPrev_q;
    assign anyPending = |(flags_q & intCtrl_q[NUM_EVENTS-1:0]);

    // ****************************************
    // Next-state logic
    // ****************************************
    // Register writes, counter, flag update
    always_comb begin
        indCtrl_d = indCtrl_q;
        rxErr_d = rxErr_q;
        intCtrl_d = intCtrl_q;
        flags_d = flags_q;
        rdata_d = 16'h0000;
        // Counter saturates rather than wrapping; software clears by write
        if (rxErrPulse && (rxErr_q != RXERR_CNT_MAX)) begin
            rxErr_d = rxErr_q + 16'h0001;
        end
        if (req.wr) begin
            case (req.addr)
                REG_IND_CTRL: indCtrl_d = req.wdata;
                REG_RXERR_CNT: rxErr_d = req.wdata;
                REG_INT_CTRL: intCtrl_d = req.wdata;
                REG_INT_FLAGS: begin
                    // Write one clears; re-setup keeps flags whose cause persists
                    if (intCtrl_q[INT_RESETUP_BIT]) begin
                        flags_d = flags_q & ~(req.wdata[NUM_EVENTS-1:0] & ~evtCond);
                    end else begin
                        flags_d = flags_q & ~req.wdata[NUM_EVENTS-1:0];
                    end
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                REG_IND_CTRL: rdata_d = indCtrl_q;
                REG_RXERR_CNT: rdata_d = rxErr_q;
                REG_INT_CTRL: rdata_d = intCtrl_q;
                REG_INT_FLAGS: begin
                    rdata_d = {5'h00, flags_q};
                    if (intCtrl_q[INT_RDCLR_BIT]) begin
                        flags_d = 11'h000;
                    end
                end
                default: rdata_d = 16'h0000;
            endcase
        end
        // Condition gone with auto clear on drops the flag
        if (intCtrl_q[INT_AUTOCLR_BIT]) begin
            flags_d = flags_d & evtCond;
        end
        // New events win over any clear in the same cycle
        flags_d = flags_d | evtRise;
    end

    // ****************************************
    // Output next values
    // ****************************************
    // Pin levels worked out here, registered below so the pins never glitch
    always_comb begin
        ind1_d = pickSrc(indCtrl_q[IND1_LSB +: 3], linkSt, 1'b0);
        ind0_d = pickSrc(indCtrl_q[IND0_LSB +: 3], linkSt, linkSt.link);
        // Active level follows polarity; pin released when disabled
        int_d = intCtrl_q[INT_POL_BIT] ? anyPending : ~anyPending;
        oe_d = ~intCtrl_q[INT_OE_BIT];
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            indCtrl_q <= IND_CTRL_RST;
            rxErr_q <= RXERR_CNT_RST;
            intCtrl_q <= INT_CTRL_RST;
            flags_q <= 11'h000;
            evtPrev_q <= 11'h000;
            rdata <= 16'h0000;
            ind1_q <= 1'b0;
            ind0_q <= 1'b0;
            int_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            indCtrl_q <= indCtrl_d;
            rxErr_q <= rxErr_d;
            intCtrl_q <= intCtrl_d;
            flags_q <= flags_d;
            evtPrev_q <= evtCond;
            rdata <= rdata_d;
            ind1_q <= ind1_d;
            ind0_q <= ind0_d;
            int_q <= int_d;
            oe_q <= oe_d;
        end
    end

    assign indicatorOne = ind1_q;
    assign indicatorZero = ind0_q;
    assign intOut = int_q;
    assign intOe_n = oe_q;

    // ****************************************
    // Assertions
    // ****************************************
    // Pin level tracks pending flags one cycle late, high polarity
    a_int_pin_level: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (!intOe_n && $past(intCtrl_q[INT_POL_BIT])) |-> (intOut == $past(anyPending)))
        else $error("interrupt level does not follow pending flags");
    // Low polarity shows the inverse of the same pending level
    a_int_low_level: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 (!intOe_n && !$past(intCtrl_q[INT_POL_BIT])) |-> (intOut == !$past(anyPending)))
        else $error("low polarity level does not follow pending flags");
    // Disabled output leaves the pin to the board
    a_pin_released: assert property (@(posedge ref_clk) disable iff (rst)
        !intCtrl_q[INT_OE_BIT] |=> intOe_n)
        else $error("interrupt pin driven while disabled");
    // Enabled output drives the pin
    a_pin_driven: assert property (@(posedge ref_clk) disable iff (rst)
        intCtrl_q[INT_OE_BIT] |=> !intOe_n)
        else $error("interrupt pin not driven while enabled");
    // Code seven turns indicator one off whatever the link does
    a_ind1_off: assert property (@(posedge ref_clk) disable iff (rst)
        (indCtrl_q[IND1_LSB +: 3] == IND_SPECIAL) |=> !indicatorOne)
        else $error("indicator one not off for code 7");
    // Code seven on indicator zero shows link status instead
    a_ind0_link: assert property (@(posedge ref_clk) disable iff (rst)
        (indCtrl_q[IND0_LSB +: 3] == IND_SPECIAL) |=> (indicatorZero == $past(linkSt.link)))
        else $error("indicator zero not link status for code 7");
    // A write in the same cycle wins, so only unwritten cycles are checked
    a_cnt_incr: assert property (@(posedge ref_clk) disable iff (rst)
        (rxErrPulse && !req.wr && rxErr_q != RXERR_CNT_MAX)
        |=> (rxErr_q == $past(rxErr_q) + 16'h0001))
        else $error("receive error counter missed an error");
    // Counter holds at full scale instead of wrapping to zero
    a_cnt_saturate: assert property (@(posedge ref_clk) disable iff (rst)
        (rxErrPulse && !req.wr && rxErr_q == RXERR_CNT_MAX) |=> (rxErr_q == RXERR_CNT_MAX))
        else $error("receive error counter wrapped");
    // A read of the flags returns them as they stood at the read edge
    a_flag_read: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == REG_INT_FLAGS) |=> (rdata == {5'h00, $past(flags_q)}))
        else $error("flag read returned wrong value");
    // Every onset leaves its flag set, whatever clear falls with it
    a_flag_onset: assert property (@(posedge ref_clk) disable iff (rst)
        (evtRise != '0) |=> ((flags_q & $past(evtRise)) == $past(evtRise)))
        else $error("event onset did not set its flag");
    // Interrupt configuration reads back as it stands
    a_read_ctrl: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == REG_INT_CTRL) |=> (rdata == $past(intCtrl_q)))
        else $error("interrupt config read back wrong");
    // Read clear only checked when no onset races the read
    a_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == REG_INT_FLAGS && intCtrl_q[INT_RDCLR_BIT] && evtRise == '0)
        |=> flags_q == '0)
        else $error("flags not cleared by read");
    // Plain read must not lose any flag
    a_read_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (req.rd && !req.wr && !intCtrl_q[INT_RDCLR_BIT] && !intCtrl_q[INT_AUTOCLR_BIT])
        |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flags lost on read without read clear");
    // Auto clear leaves no flag whose condition was low
    a_auto_clear: assert property (@(posedge ref_clk) disable iff (rst)
        intCtrl_q[INT_AUTOCLR_BIT] |=> (flags_q & ~$past(evtCond) & ~evtPrev_q) == '0)
        else $error("flag held after condition gone");
    // Re-setup keeps flags whose cause is still present
    a_resetup_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == REG_INT_FLAGS && intCtrl_q[INT_RESETUP_BIT])
        |=> ((flags_q & $past(flags_q & evtCond)) == $past(flags_q & evtCond)))
        else $error("re-setup flag cleared while condition present");
    // Without re-setup a written one clears its flag; only cycles with no onset are checked
    a_w1c_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (req.wr && req.addr == REG_INT_FLAGS && !intCtrl_q[INT_RESETUP_BIT] && evtRise == '0)
        |=> (flags_q & $past(req.wdata[NUM_EVENTS-1:0])) == '0)
        else $error("write one did not clear flag");
endmodule
`default_nettype wire

// File: bench/plic_mgmt_model.sv
// Purpose: Management controller model driving the register port
// Assumes: One request at a time; read data stands in the cycle after the read edge
// Notes: Requests change just after a rising edge and are held over one edge
`default_nettype none
module plic_mgmt_model
    import plic_pkg::*;
(
    input wire logic ref_clk,
    output var plic_req_t req,
    input wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port from time zero, so no stray strobe during reset
    initial req = '0;
    // Write strobe for one edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk) req <= '0;
    endtask
    // Read strobe; data is taken just after the sampling edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge ref_clk) req <= '0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

// File: bench/phy_led_select_and_interrupt_control_bench.sv
// Purpose: Self-checking bench for indicator select and interrupt control
// Assumes: Events are levels; flag and pin settle within three cycles
// Notes: Each scenario is one task
`default_nettype none
module phy_led_select_and_interrupt_control_bench
    import plic_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic rxErrPulse = 1'b0;
    logic indicatorOne, indicatorZero, intOut, intOe_n;
    plic_req_t req;
    plic_link_t linkSt = '0;
    logic [10:0] evtCond = '0;
    logic [15:0] rdata, v;
    logic [6:0] lv;
    int error_cnt = 0;
    int checked = 0;
    // 25 MHz clock
    initial forever #20 ref_clk = ~ref_clk;
    plic_ctrl dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .linkSt(linkSt),
        .rxErrPulse(rxErrPulse), .evtCond(evtCond), .indicatorOne(indicatorOne),
        .indicatorZero(indicatorZero), .intOut(intOut), .intOe_n(intOe_n));
    plic_mgmt_model mdl (.ref_clk(ref_clk), .req(req), .rdata(rdata));
    // Compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        mdl.rd(a, v);
        chk(v, e);
    endtask
    // Event level change, then let flag and pin settle
    task automatic setc(input int i, input logic b);
        @(posedge ref_clk) evtCond[i] <= b;
        cyc(3);
    endtask
    // Reset values and an unmapped read
    task automatic t_reset;
        rdchk(REG_IND_CTRL, IND_CTRL_RST);
        rdchk(REG_RXERR_CNT, 16'h0000);
        rdchk(REG_INT_CTRL, INT_CTRL_RST);
        rdchk(5'h1f, 16'h0000);
        chk({15'h0, intOe_n}, 16'h0001);
    endtask
    // Every code on both indicators, two opposite link patterns
    task automatic t_ind;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                lv = p ? 7'h2a : 7'h55;
                @(posedge ref_clk) linkSt <= lv;
                mdl.wr(REG_IND_CTRL, 16'h3fc0 | 16'(c * 9));
                cyc(2);
                chk({15'h0, indicatorOne}, {15'h0, c == 7 ? 1'b0 : lv[6 - c]});
                chk({15'h0, indicatorZero}, {15'h0, lv[c == 7 ? 6 : 6 - c]});
            end
        end
    endtask
    // Counter written near the top, counts and saturates
    task automatic t_cnt;
        mdl.wr(REG_RXERR_CNT, 16'hfffe);
        repeat (2) begin
            @(posedge ref_clk) rxErrPulse <= 1'b1;
            @(posedge ref_clk) rxErrPulse <= 1'b0;
        end
        rdchk(REG_RXERR_CNT, 16'hffff);
    endtask
    // Each event alone, low polarity, read-clear on
    task automatic t_evt;
        for (int i = 0; i < 11; i++) begin
            mdl.wr(REG_INT_CTRL, 16'hc000 | 16'(1 << i));
            setc(i, 1'b1);
            chk({15'h0, intOut}, 16'h0000);
            chk({15'h0, intOe_n}, 16'h0000);
            rdchk(REG_INT_FLAGS, 16'(1 << i));
            rdchk(REG_INT_FLAGS, 16'h0000);
            setc(i, 1'b0);
        end
    endtask
    // Clear policies, high polarity, masked event
    task automatic t_clr;
        mdl.wr(REG_INT_CTRL, 16'ha001);
        setc(1, 1'b1);
        chk({15'h0, intOut}, 16'h0000);
        setc(0, 1'b1);
        chk({15'h0, intOut}, 16'h0001);
        rdchk(REG_INT_FLAGS, 16'h0003);
        mdl.wr(REG_INT_FLAGS, 16'h0003);
        rdchk(REG_INT_FLAGS, 16'h0000);
        setc(0, 1'b0);
        mdl.wr(REG_INT_CTRL, 16'ha801);
        setc(0, 1'b1);
        mdl.wr(REG_INT_FLAGS, 16'h0001);
        rdchk(REG_INT_FLAGS, 16'h0001);
        mdl.wr(REG_INT_CTRL, 16'hb001);
        setc(0, 1'b0);
        rdchk(REG_INT_FLAGS, 16'h0000);
        mdl.wr(REG_INT_CTRL, 16'h2001);
        setc(0, 1'b1);
        setc(0, 1'b0);
        rdchk(REG_INT_FLAGS, 16'h0001);
        chk({15'h0, intOe_n}, 16'h0001);
        rdchk(REG_INT_CTRL, 16'h2001);
        setc(1, 1'b0);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset;
        t_ind;
        t_cnt;
        t_evt;
        t_clr;
        report_and_stop;
    end
    // Hang guard, counted as a mismatch
    initial begin
        cyc(60000);
        error_cnt++;
        report_and_stop;
    end
endmodule
`default_nettype wire
